// ===== hw/floppy_ctl_status_and_cmd_regs.sv
`timescale 1ns/100ps
// Function
// [R1] Offsets 0-5 and 7 decoded; offsets 4 and 7 differ for read and write.
// [R2] Unknown command code does nothing and returns one result byte 80H.
// [R3] Register dump returns ten bytes of cylinders, timings and settings.
// [R4] Sense drive status takes one unit byte and returns one status byte.
// [R5] Monitor A bit 7 follows the interrupt output in both modes.
// [R6] First mode: monitor A bit 6 reads 0 when a second drive exists.
// [R7] Monitor A bit 5 is inverted step pulse; second mode uses a latched copy.
// [R8] Monitor A bit 4 is track zero true, inverted in second mode.
// [R9] Monitor A bit 3 is inverted side output, true level in second mode.
// [R10] Monitor A bit 2 is rotation mark true, inverted in second mode.
// [R11] Monitor A bit 1 is 0 when protected in first mode, 1 in second.
// [R12] Monitor A bit 0 is direction, 1 inward first mode, reversed second.
// [R13] Second mode: monitor A bit 6 follows the DMA request line.
// [R14] First mode: monitor B bit 5 mirrors motor select bit 0.
// [R15] First mode: monitor B bit 4 toggles on write serial rising edges.
// [R16] First mode: monitor B bit 3 toggles on read serial rising edges.
// [R17] First mode: monitor B bit 2 is inverted write gate.
// [R18] First mode: monitor B bits 1,0 are inverted motor B and A.
// [R19] Second mode: monitor B bits 6,5 unit selects, bit 7 second unit.
// [R20] Second mode: monitor B bit 4 inverse of write serial latched at edges.
// [R21] Second mode: monitor B bit 3 inverse of latched read serial.
// [R22] Configure takes three bytes and updates settings with no result.
// [R23] Lock takes freeze in code bit 7 and returns it in bit 4.
// [R24] Relative seek: direction in code bit 6, unit byte, step count byte.
// [R25] Perpendicular mode takes one byte of overwrite, enables, gap, gate.
module floppy_ctl_status_and_cmd_regs (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic modeSecond,
    input wire logic irqLevel,
    input wire logic dmaReqLevel,
    input wire fdc_regs_pkg::drivePins_type pins,
    input wire fdc_regs_pkg::hostReq_type req,
    output logic [7:0] rdata,
    output logic [7:0] motorSelectCtl,
    output logic [1:0] tapeSelect,
    output logic [1:0] dataRate,
    output logic cmdBusy
);

    typedef enum logic [1:0] {stIdle, stParam, stResult} phase_type;

    phase_type phase;
    logic [7:0] opcode;
    logic [3:0] paramLeft;
    logic [3:0] paramIdx;
    logic [7:0] unitByte;
    logic [7:0] resBuf [0:9];
    logic [3:0] resLen;
    logic [3:0] resIdx;
    logic [7:0] cylinder [0:3];
    logic [7:0] timingA;
    logic [7:0] timingB;
    logic [7:0] finalSectorNumber;
    logic paramFreeze;
    logic [3:0] perpEnable;
    logic interrecordLenSelect;
    logic writeGateFmt;
    logic impliedSeekOn;
    logic fifoOff;
    logic periodicReadyCheckOff;
    logic [3:0] fifoThreshold;
    logic [7:0] precompStartCyl;
    logic noPrecomp;
    logic wrPrev;
    logic rdPrev;
    logic stepLatched;
    logic readLatched;
    logic wrEdgeLatched;
    logic wrToggle;
    logic rdToggle;
    logic [7:0] next_rdata;
    logic [7:0] monA;
    logic [7:0] monB;
    logic [7:0] mainStat;
    logic [7:0] diag;
    logic fifoWrite;
    logic fifoRead;

    //////////////////////////////////////////////////////////////////////////
    function automatic logic [3:0] paramCount(input logic [7:0] op);
        logic [3:0] n;
        n = 4'h0;
        if (op == fdc_regs_pkg::OP_SPECIFY) begin
            n = 4'h2;
        end else if (op == fdc_regs_pkg::OP_SENSE_DRIVE || op == fdc_regs_pkg::OP_PERP) begin
            n = 4'h1;
        end else if (op == fdc_regs_pkg::OP_CONFIGURE) begin
            n = fdc_regs_pkg::CONFIGURE_LEN;
        end else if (op[7] && op[5:0] == fdc_regs_pkg::OP_RSEEK_LOW) begin
            n = fdc_regs_pkg::RSEEK_LEN;
        end
        return n;
    endfunction

    function automatic logic rising(input logic prev, input logic now);
        return !prev && now;
    endfunction

    assign fifoWrite = ce && req.wrStrobe && req.addr == fdc_regs_pkg::OFF_FIFO;
    assign fifoRead = ce && req.rdStrobe && req.addr == fdc_regs_pkg::OFF_FIFO;
    assign cmdBusy = phase != stIdle;

    //////////////////////////////////////////////////////////////////////////
    // Write-side registers at offsets 2, 3, 4 and 7.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            motorSelectCtl <= fdc_regs_pkg::MOTOR_RESET;
            tapeSelect <= 2'h0;
            dataRate <= fdc_regs_pkg::RATE_RESET;
            noPrecomp <= 1'b0;
        end else if (ce && req.wrStrobe) begin
            case (req.addr) // [R1]
                fdc_regs_pkg::OFF_MOTOR: begin
                    motorSelectCtl <= req.wdata;
                end
                fdc_regs_pkg::OFF_TAPE: begin
                    tapeSelect <= req.wdata[1:0];
                end
                fdc_regs_pkg::OFF_RATE_SEL: begin
                    dataRate <= req.wdata[1:0];
                end
                fdc_regs_pkg::OFF_RATE_CFG: begin
                    dataRate <= req.wdata[1:0];
                    noPrecomp <= req.wdata[2];
                end
                default: begin
                end
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Pin history for toggles and latched copies.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            // The serial pins idle high, so history starts high; otherwise reset fakes a rising edge.
            wrPrev <= 1'b1;
            rdPrev <= 1'b1;
            stepLatched <= 1'b0;
            readLatched <= 1'b0;
            wrEdgeLatched <= 1'b0;
            wrToggle <= 1'b0;
            rdToggle <= 1'b0;
        end else if (ce) begin
            wrPrev <= pins.writeSerialOutN;
            rdPrev <= pins.readSerialInN;
            stepLatched <= pins.headPulseOutN; // [R7]
            readLatched <= pins.readSerialInN; // [R21]
            if (rising(wrPrev, pins.writeSerialOutN)) begin
                wrToggle <= !wrToggle; // [R15]
                wrEdgeLatched <= pins.writeSerialOutN; // [R20]
            end
            if (rising(rdPrev, pins.readSerialInN)) begin
                rdToggle <= !rdToggle; // [R16]
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Pin monitors in the two compatibility modes.
    always_comb begin
        monA[7] = irqLevel; // [R5]
        if (!modeSecond) begin
            monA[6] = pins.secondUnitPresentN; // [R6]
            monA[5] = !pins.headPulseOutN; // [R7]
            monA[4] = pins.trackZeroInN; // [R8]
            monA[3] = !pins.sideOutN; // [R9]
            monA[2] = pins.rotationMarkInN; // [R10]
            monA[1] = pins.writeProtectN; // [R11]
            monA[0] = pins.headDirIn; // [R12]
            monB = {2'b11, motorSelectCtl[0], wrToggle, rdToggle, // [R14]
                    !pins.writeGateOutN, !pins.motorBOnN, !pins.motorAOnN}; // [R17] [R18]
        end else begin
            monA[6] = dmaReqLevel; // [R13]
            monA[5] = !stepLatched; // [R7]
            monA[4] = !pins.trackZeroInN; // [R8]
            monA[3] = pins.sideOutN; // [R9]
            monA[2] = !pins.rotationMarkInN; // [R10]
            monA[1] = !pins.writeProtectN; // [R11]
            monA[0] = !pins.headDirIn; // [R12]
            monB = {pins.secondUnitPresentN, pins.unitBSelectedN, pins.unitASelectedN, // [R19]
                    !wrEdgeLatched, !readLatched, !pins.writeGateOutN, // [R20] [R21]
                    pins.unitBSelectedN, pins.unitASelectedN};
        end
    end

    always_comb begin
        mainStat = 8'h00;
        mainStat[fdc_regs_pkg::MS_READY_BIT] = 1'b1;
        mainStat[fdc_regs_pkg::MS_DIR_BIT] = phase == stResult;
        mainStat[fdc_regs_pkg::MS_BUSY_BIT] = phase != stIdle;
        if (modeSecond) begin
            diag = {pins.diskChangeN, 3'b111, motorSelectCtl[3], noPrecomp, dataRate};
        end else begin
            diag = {!pins.diskChangeN, 4'hf, dataRate, !dataRate[0]};
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Read port; data stand only in the cycle after the strobe.
    always_comb begin
        next_rdata = 8'h00;
        case (req.addr) // [R1]
            fdc_regs_pkg::OFF_MON_A: next_rdata = monA;
            fdc_regs_pkg::OFF_MON_B: next_rdata = monB;
            fdc_regs_pkg::OFF_TAPE: next_rdata = {6'h00, tapeSelect};
            fdc_regs_pkg::OFF_MAIN_STAT: next_rdata = mainStat;
            fdc_regs_pkg::OFF_FIFO: next_rdata = phase == stResult ? resBuf[resIdx] : 8'h00;
            fdc_regs_pkg::OFF_DIAG: next_rdata = diag;
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdata <= 8'h00;
        end else if (ce) begin
            rdata <= req.rdStrobe ? next_rdata : 8'h00;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Command sequencer on the data port.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            phase <= stIdle;
            opcode <= 8'h00;
            paramLeft <= 4'h0;
            paramIdx <= 4'h0;
            unitByte <= 8'h00;
            resLen <= 4'h0;
            resIdx <= 4'h0;
            for (int i = 0; i < 10; i++) begin
                resBuf[i] <= 8'h00;
            end
        end else if (ce) begin
            case (phase)
                stIdle: begin
                    resIdx <= 4'h0;
                    paramIdx <= 4'h0;
                    if (fifoWrite) begin
                        opcode <= req.wdata;
                        paramLeft <= paramCount(req.wdata);
                        if (paramCount(req.wdata) != 4'h0) begin
                            phase <= stParam;
                        end else if (req.wdata == fdc_regs_pkg::OP_DUMP) begin
                            resBuf[0] <= cylinder[0]; // [R3]
                            resBuf[1] <= cylinder[1];
                            resBuf[2] <= cylinder[2];
                            resBuf[3] <= cylinder[3];
                            resBuf[4] <= timingA;
                            resBuf[5] <= timingB;
                            resBuf[6] <= finalSectorNumber;
                            resBuf[7] <= {paramFreeze, 1'b0, perpEnable, interrecordLenSelect, writeGateFmt};
                            resBuf[8] <= {1'b0, impliedSeekOn, fifoOff, periodicReadyCheckOff, fifoThreshold};
                            resBuf[9] <= precompStartCyl;
                            resLen <= fdc_regs_pkg::DUMP_LEN;
                            phase <= stResult;
                        end else if (req.wdata[6:0] == fdc_regs_pkg::OP_LOCK_LOW) begin
                            resBuf[0] <= {3'b000, req.wdata[7], 4'h0}; // [R23]
                            resLen <= 4'h1;
                            phase <= stResult;
                        end else begin
                            resBuf[0] <= fdc_regs_pkg::INVALID_ST0; // [R2]
                            resLen <= 4'h1;
                            phase <= stResult;
                        end
                    end
                end
                stParam: begin
                    if (fifoWrite) begin
                        paramLeft <= paramLeft - 4'h1;
                        paramIdx <= paramIdx + 4'h1;
                        if (paramIdx == 4'h0) begin
                            unitByte <= req.wdata;
                        end
                        if (paramLeft == 4'h1) begin
                            if (opcode == fdc_regs_pkg::OP_SENSE_DRIVE) begin
                                // Fault and ready are not wired to this block: fault 0, ready 1, two-sided 1.
                                resBuf[0] <= {1'b0, !pins.writeProtectN, 1'b1, !pins.trackZeroInN, // [R4]
                                              1'b1, req.wdata[2:0]};
                                resLen <= 4'h1;
                                phase <= stResult;
                            end else begin
                                phase <= stIdle; // [R22]
                            end
                        end
                    end
                end
                stResult: begin
                    if (fifoRead) begin
                        resIdx <= resIdx + 4'h1;
                        if (resIdx + 4'h1 == resLen) begin
                            phase <= stIdle;
                        end
                    end
                end
                default: begin
                    phase <= stIdle;
                end
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Settings written by command parameters.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            timingA <= 8'h00;
            timingB <= 8'h00;
            finalSectorNumber <= fdc_regs_pkg::EOT_RESET;
            paramFreeze <= 1'b0;
            perpEnable <= 4'h0;
            interrecordLenSelect <= 1'b0;
            writeGateFmt <= 1'b0;
            impliedSeekOn <= 1'b0;
            fifoOff <= 1'b0;
            periodicReadyCheckOff <= 1'b0;
            fifoThreshold <= fdc_regs_pkg::FIFO_THR_RESET;
            precompStartCyl <= fdc_regs_pkg::PRECOMP_RESET;
            for (int i = 0; i < 4; i++) begin
                cylinder[i] <= fdc_regs_pkg::CYL_RESET;
            end
        end else if (ce) begin
            if (phase == stIdle && fifoWrite && req.wdata[6:0] == fdc_regs_pkg::OP_LOCK_LOW) begin
                paramFreeze <= req.wdata[7]; // [R23]
            end
            if (phase == stParam && fifoWrite) begin
                if (opcode == fdc_regs_pkg::OP_SPECIFY) begin
                    if (paramIdx == 4'h0) begin
                        timingA <= req.wdata;
                    end else begin
                        timingB <= req.wdata;
                    end
                end
                if (opcode == fdc_regs_pkg::OP_PERP) begin
                    // Drive enables change only when the overwrite bit is set.
                    if (req.wdata[7]) begin
                        perpEnable <= req.wdata[5:2]; // [R25]
                    end
                    interrecordLenSelect <= req.wdata[1];
                    writeGateFmt <= req.wdata[0];
                end
                if (opcode == fdc_regs_pkg::OP_CONFIGURE) begin
                    if (paramIdx == 4'h1) begin
                        impliedSeekOn <= req.wdata[6]; // [R22]
                        fifoOff <= req.wdata[5];
                        periodicReadyCheckOff <= req.wdata[4];
                        fifoThreshold <= req.wdata[3:0];
                    end else if (paramIdx == 4'h2) begin
                        precompStartCyl <= req.wdata;
                    end
                end
                if (opcode[7] && opcode[5:0] == fdc_regs_pkg::OP_RSEEK_LOW && paramIdx == 4'h1) begin
                    // The cylinder wraps; the step count is not range-checked.
                    if (opcode[6]) begin
                        cylinder[unitByte[1:0]] <= cylinder[unitByte[1:0]] + req.wdata; // [R24]
                    end else begin
                        cylinder[unitByte[1:0]] <= cylinder[unitByte[1:0]] - req.wdata; // [R24]
                    end
                end
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    property p_irq_bit;
        @(posedge core_clk) disable iff (rst)
        ce && req.rdStrobe && req.addr == fdc_regs_pkg::OFF_MON_A |=> rdata[7] == $past(irqLevel);
    endproperty
    a_irq_bit: assert property (p_irq_bit) else $error("monitor A bit 7 wrong"); // [R5]

    property p_track_bit;
        @(posedge core_clk) disable iff (rst)
        ce && req.rdStrobe && req.addr == fdc_regs_pkg::OFF_MON_A
            |=> rdata[4] == ($past(pins.trackZeroInN) ^ $past(modeSecond));
    endproperty
    a_track_bit: assert property (p_track_bit) else $error("monitor A bit 4 wrong"); // [R8]

    property p_wprot_bit;
        @(posedge core_clk) disable iff (rst)
        ce && req.rdStrobe && req.addr == fdc_regs_pkg::OFF_MON_A
            |=> rdata[1] == ($past(pins.writeProtectN) ^ $past(modeSecond));
    endproperty
    a_wprot_bit: assert property (p_wprot_bit) else $error("monitor A bit 1 wrong"); // [R11]

    property p_dsel_bit;
        @(posedge core_clk) disable iff (rst)
        ce && req.rdStrobe && req.addr == fdc_regs_pkg::OFF_MON_B && !modeSecond
            |=> rdata[5] == motorSelectCtl[0];
    endproperty
    a_dsel_bit: assert property (p_dsel_bit) else $error("monitor B bit 5 wrong"); // [R14]

    property p_wr_toggle;
        @(posedge core_clk) disable iff (rst)
        ce && rising(wrPrev, pins.writeSerialOutN) |=> wrToggle != $past(wrToggle);
    endproperty
    a_wr_toggle: assert property (p_wr_toggle) else $error("write toggle missed"); // [R15]

    property p_invalid;
        @(posedge core_clk) disable iff (rst)
        phase == stIdle && fifoWrite && paramCount(req.wdata) == 4'h0 && req.wdata != fdc_regs_pkg::OP_DUMP
            && req.wdata[6:0] != fdc_regs_pkg::OP_LOCK_LOW
            |=> phase == stResult && resLen == 4'h1 && resBuf[0] == fdc_regs_pkg::INVALID_ST0;
    endproperty
    a_invalid: assert property (p_invalid) else $error("invalid code result wrong"); // [R2]

    property p_dump_len;
        @(posedge core_clk) disable iff (rst)
        phase == stIdle && fifoWrite && req.wdata == fdc_regs_pkg::OP_DUMP
            |=> resLen == fdc_regs_pkg::DUMP_LEN && resBuf[9] == precompStartCyl;
    endproperty
    a_dump_len: assert property (p_dump_len) else $error("dump result wrong"); // [R3]

    property p_lock;
        @(posedge core_clk) disable iff (rst)
        phase == stIdle && fifoWrite && req.wdata[6:0] == fdc_regs_pkg::OP_LOCK_LOW
            |=> resBuf[0] == {3'b000, paramFreeze, 4'h0} && phase == stResult;
    endproperty
    a_lock: assert property (p_lock) else $error("lock result wrong"); // [R23]

    property p_configure_silent;
        @(posedge core_clk) disable iff (rst)
        phase == stParam && fifoWrite && opcode == fdc_regs_pkg::OP_CONFIGURE && paramLeft == 4'h1
            |=> phase == stIdle && precompStartCyl == $past(req.wdata);
    endproperty
    a_configure_silent: assert property (p_configure_silent) else $error("configure mishandled"); // [R22]

    c_dump: cover property (@(posedge core_clk) disable iff (rst)
        phase == stResult && resLen == fdc_regs_pkg::DUMP_LEN ##1 phase == stIdle);
    c_sense: cover property (@(posedge core_clk) disable iff (rst)
        phase == stParam && opcode == fdc_regs_pkg::OP_SENSE_DRIVE ##1 phase == stResult);
    c_second_mode_read: cover property (@(posedge core_clk) disable iff (rst)
        modeSecond && req.rdStrobe && req.addr == fdc_regs_pkg::OFF_MON_B);

endmodule

// ===== hw/fdc_regs_pkg.sv
package fdc_regs_pkg;

    // Register offsets; offsets 4 and 7 select a different register on write.
    localparam logic [2:0] OFF_MON_A = 3'h0;
    localparam logic [2:0] OFF_MON_B = 3'h1;
    localparam logic [2:0] OFF_MOTOR = 3'h2;
    localparam logic [2:0] OFF_TAPE = 3'h3;
    localparam logic [2:0] OFF_MAIN_STAT = 3'h4;
    localparam logic [2:0] OFF_RATE_SEL = 3'h4;
    localparam logic [2:0] OFF_FIFO = 3'h5;
    localparam logic [2:0] OFF_DIAG = 3'h7;
    localparam logic [2:0] OFF_RATE_CFG = 3'h7;

    // Command codes.
    localparam logic [7:0] OP_SPECIFY = 8'h03;
    localparam logic [7:0] OP_SENSE_DRIVE = 8'h04;
    localparam logic [7:0] OP_DUMP = 8'h0e;
    localparam logic [7:0] OP_PERP = 8'h12;
    localparam logic [7:0] OP_CONFIGURE = 8'h13;
    localparam logic [6:0] OP_LOCK_LOW = 7'h14;
    localparam logic [5:0] OP_RSEEK_LOW = 6'h0f;

    // Result and parameter counts.
    localparam logic [7:0] INVALID_ST0 = 8'h80;
    localparam logic [3:0] DUMP_LEN = 4'ha;
    localparam logic [3:0] CONFIGURE_LEN = 4'h3;
    localparam logic [3:0] RSEEK_LEN = 4'h2;

    // Values after reset.
    localparam logic [7:0] MOTOR_RESET = 8'h00;
    localparam logic [7:0] CYL_RESET = 8'h00;
    localparam logic [7:0] EOT_RESET = 8'h00;
    localparam logic [3:0] FIFO_THR_RESET = 4'h0;
    localparam logic [7:0] PRECOMP_RESET = 8'h00;
    localparam logic [1:0] RATE_RESET = 2'h0;

    // Main handshake status bit positions.
    localparam int MS_READY_BIT = 7;
    localparam int MS_DIR_BIT = 6;
    localparam int MS_BUSY_BIT = 4;

    // Drive-side pin levels as seen by the block, active-low pins as printed.
    typedef struct packed {
        logic secondUnitPresentN;
        logic headPulseOutN;
        logic trackZeroInN;
        logic sideOutN;
        logic rotationMarkInN;
        logic writeProtectN;
        logic headDirIn;
        logic writeSerialOutN;
        logic readSerialInN;
        logic writeGateOutN;
        logic motorAOnN;
        logic motorBOnN;
        logic unitASelectedN;
        logic unitBSelectedN;
        logic diskChangeN;
    } drivePins_type;

    // Register access from the host.
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wrStrobe;
        logic rdStrobe;
    } hostReq_type;

endpackage

// ===== tb/host_model.sv
`timescale 1ns/100ps
// Host processor: each access holds its strobe for one sampling edge, then releases everything.
module host_model (
    input wire logic core_clk,
    output fdc_regs_pkg::hostReq_type req
);
    initial req = '0;
    task automatic access(input logic [2:0] a, input logic [7:0] d, input logic w);
        @(posedge core_clk);
        req <= '{a, d, w, !w};
        @(posedge core_clk);
        req <= '0;
    endtask
endmodule

// ===== tb/testbench.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin checksDone++; if ((g) !== (e)) begin fails++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module testbench;
    logic core_clk = 0, rst = 1, modeSecond = 0, irqLevel = 0, dmaReqLevel = 0, rdWas = 0;
    logic busy, prevWr = 1, prevRd = 1, togWr = 0, togRd = 0, latWr = 0;
    fdc_regs_pkg::drivePins_type pins = '1;
    fdc_regs_pkg::hostReq_type req;
    logic [7:0] rdata, motorSelectCtl, m;
    logic [1:0] tapeSelect, dataRate;
    logic [15:0] expQ[$], note;
    logic [7:0] cmd[$] = '{8'h13, 8'h00, 8'h35, 8'h5a, 8'h03, 8'hab, 8'h47, 8'h12, 8'hbd, 8'hcf, 8'h01, 8'h05};
    logic [7:0] dmp[10] = '{8'h00, 8'h05, 8'h00, 8'h00, 8'hab, 8'h47, 8'h00, 8'hbd, 8'h35, 8'h5a};
    int fails = 0, checksDone = 0;
    integer seed = 32'hcd7abbb3;
    initial forever #4 core_clk = ~core_clk;
    host_model host (.core_clk(core_clk), .req(req));
    floppy_ctl_status_and_cmd_regs dut (.core_clk(core_clk), .rst(rst), .ce(1'b1), .modeSecond(modeSecond),
        .irqLevel(irqLevel), .dmaReqLevel(dmaReqLevel), .pins(pins), .req(req), .rdata(rdata),
        .motorSelectCtl(motorSelectCtl), .tapeSelect(tapeSelect), .dataRate(dataRate), .cmdBusy(busy));
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        host.access(a, d, 1'b1);
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] k);
        host.access(a, 8'h00, 1'b0);
        expQ.push_back({k, e});
    endtask
    function automatic logic [7:0] expA(input logic s, input fdc_regs_pkg::drivePins_type p);
        expA = s ? {irqLevel, dmaReqLevel, !p.headPulseOutN, !p.trackZeroInN, p.sideOutN, !p.rotationMarkInN,
            !p.writeProtectN, !p.headDirIn} : {irqLevel, p.secondUnitPresentN, !p.headPulseOutN, p.trackZeroInN,
            !p.sideOutN, p.rotationMarkInN, p.writeProtectN, p.headDirIn};
    endfunction
    ////////////////////////////////////////////////////////////////////////
    // Read data stand only in the cycle after the strobe, so they are sampled mid-cycle to avoid edge races.
    always @(posedge core_clk) rdWas <= req.rdStrobe;
    // Reference for the edge-driven monitor bits; the pins idle high, so reset must not count an edge.
    always @(posedge core_clk) begin
        if (!rst) begin
            prevWr <= pins.writeSerialOutN;
            prevRd <= pins.readSerialInN;
            if (!prevWr && pins.writeSerialOutN) begin
                togWr <= !togWr;
                latWr <= 1'b1;
            end
            if (!prevRd && pins.readSerialInN) togRd <= !togRd;
        end
    end
    always @(negedge core_clk) begin
        if (rdWas) begin
            note = expQ.pop_front();
            `CHK("rdata", note[7:0], rdata & note[15:8])
        end
    end
    task automatic completeRun;
        $display("checks %0d mismatches %0d", checksDone, fails);
        if (fails == 0 && checksDone > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        #100000;
        fails++;
        completeRun;
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge core_clk);
        rst <= 0;
        for (int i = 0; i < 16; i++) begin
            @(posedge core_clk);
            modeSecond <= i[3];
            pins <= $random(seed);
            irqLevel <= $random(seed);
            dmaReqLevel <= $random(seed);
            m = $random(seed);
            wr(3'h2, m);
            #1 `CHK("motor", m, motorSelectCtl)
            rd(3'h0, expA(modeSecond, pins), 8'hff);
            if (modeSecond)
                rd(3'h1, {pins.secondUnitPresentN, pins.unitBSelectedN, pins.unitASelectedN, !latWr,
                    !pins.readSerialInN, 3'h0}, 8'hf8);
            else
                rd(3'h1, {2'h0, m[0], togWr, togRd, !pins.writeGateOutN, !pins.motorBOnN,
                    !pins.motorAOnN}, 8'h3f);
        end
        $display("pin monitor test done");
        rd(3'h6, 8'h00, 8'hff);
        rd(3'h2, 8'h00, 8'hff);
        wr(3'h4, 8'h02);
        #1 `CHK("rate", 2'h2, dataRate)
        wr(3'h7, 8'h01);
        #1 `CHK("rate", 2'h1, dataRate)
        wr(3'h3, 8'h02);
        #1 `CHK("tape", 2'h2, tapeSelect)
        rd(3'h3, 8'h02, 8'h03);
        rd(3'h7, {pins.diskChangeN, 3'h7, m[3], 3'h1}, 8'hff);
        $display("decode test done");
        wr(3'h5, 8'h14);
        #1 `CHK("busy", 1'b1, busy)
        rd(3'h4, 8'hd0, 8'hff);
        rd(3'h5, 8'h00, 8'hff);
        wr(3'h5, 8'h01);
        rd(3'h5, 8'h80, 8'hff);
        wr(3'h5, 8'h04);
        wr(3'h5, 8'h05);
        rd(3'h5, {1'b0, !pins.writeProtectN, 1'b1, !pins.trackZeroInN, 4'hd}, 8'hff);
        foreach (cmd[i]) wr(3'h5, cmd[i]);
        wr(3'h5, 8'h94);
        rd(3'h5, 8'h10, 8'hff);
        wr(3'h5, 8'h0e);
        foreach (dmp[i]) rd(3'h5, dmp[i], 8'hff);
        repeat (2) @(posedge core_clk);
        $display("command test done");
        completeRun;
    end
endmodule
